// ==== logic/fspc_ctrl.sv ====
// flash self-programming controller: control and key registers, unlock, start, stall
// assumes the core presents one-cycle register strobes on ref_clk and honours cpu_stall
//
// Overview of operation
// (RULE1) stall the processor while any erase or program runs; release when done
// (RULE2) operations timed by fast RC oscillator ticks; row write 11064 ticks at 7.37 MHz
// (RULE3) setting control bit 15 starts the selected operation; hardware clears it after
// (RULE4) software writes 0x55 then 0xAA to the key register consecutively
// (RULE5) key register takes bits 7-0 only; upper bits read zero
// (RULE6) software can only set the start bit; hardware alone clears it
// (RULE7) page erase needs erase bit 6 and write-enable bit 14; no write-enable, nothing
// (RULE8) bit 13 flags improper start attempts or terminations; zero after normal completion
// (RULE9) erase codes: 1111 bulk, 1101 segment, 0010 page, 0000 config; 0011/0001 nothing
// (RULE10) program codes: 0001 row, 0011 word, 0000 config; 1111/1101/0010 nothing
// (RULE11) erase granularity is one page of eight rows
// (RULE12) software loads page start address into table page and working register first
// (RULE13) software loads 64 words into holding buffers before a row program
// (RULE14) software repeats load and row program per row until 512 words written
// (RULE15) software writes low word then high byte per buffer location, then advances
// (RULE16) software runs two no-ops after setting the start bit
// (RULE17) software holds off interrupts around key writes and start to keep them consecutive
// (RULE18) 0x4042 sets up write-enabled page erase; 0x4001 write-enabled row program
// (RULE19) rows hold 64 instructions, 192 bytes, aligned from program memory start
// (RULE20) target address is table page bits 7:0 joined with 16-bit effective address
// (RULE21) any other write between key writes discards the unlock
// (RULE22) control register clears only on power-on reset, survives other resets
`timescale 1ns/1ps
`include "fspc_regs.svh"
module fspc_ctrl
	import fspc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic warm_rst,
	input wire logic fast_rc_osc,
	input wire logic reg_wr,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [7:0] table_page_reg,
	input wire logic [15:0] table_ea,
	input wire logic abort,
	output logic [15:0] reg_rdata,
	output logic cpu_stall,
	output fspc_cmd_s flash_cmd
);
	logic [15:0] ctrl_reg;
	logic [15:0] ctrl_next;
	fspc_key_e key_reg;
	fspc_key_e key_next;
	fspc_cmd_s cmd_reg;
	fspc_cmd_s cmd_next;
	logic [2:0] osc_sync_reg;
	logic osc_tick;
	logic load;
	logic launch;
	logic [15:0] load_cycles;
	logic busy;
	logic done;
	logic wr_ctrl;
	logic wr_key;
	logic start_req;
	fspc_op_e sel_op;

	// decode operation field against erase bit; unlisted codes map to nothing
	function automatic fspc_op_e decode_op(input logic erase, input logic [3:0] code);
		decode_op = FSPC_NONE;
		if (erase) begin
			case (code)
				`FSPC_OP_BULK: decode_op = FSPC_BULK; // RULE9
				`FSPC_OP_SEGMENT: decode_op = FSPC_SEGMENT;
				`FSPC_OP_PAGE: decode_op = FSPC_PAGE; // RULE11
				`FSPC_OP_CFG: decode_op = FSPC_CFG_ERASE;
				default: decode_op = FSPC_NONE;
			endcase
		end else begin
			case (code)
				`FSPC_OP_ROW: decode_op = FSPC_ROW; // RULE10
				`FSPC_OP_WORD: decode_op = FSPC_WORD;
				`FSPC_OP_CFG: decode_op = FSPC_CFG_PROG;
				default: decode_op = FSPC_NONE;
			endcase
		end
	endfunction

	// oscillator cycle budget; only the row write figure is given, bulk, segment and page reuse it; word and config use the short count
	function automatic logic [15:0] op_cycles(input fspc_op_e op);
		op_cycles = 16'(`FSPC_ROW_OSC_CYCLES); // RULE2
		if (op == FSPC_WORD || op == FSPC_CFG_PROG || op == FSPC_CFG_ERASE) begin
			op_cycles = 16'(`FSPC_SHORT_OSC_CYCLES);
		end
	endfunction

	// rows and pages sit on their own boundaries, so low address bits are dropped
	function automatic logic [23:0] align_addr(input fspc_op_e op, input logic [23:0] addr);
		align_addr = addr;
		if (op == FSPC_ROW) begin
			align_addr = addr & `FSPC_ROW_ADDR_MASK; // RULE19
		end else if (op == FSPC_PAGE) begin
			align_addr = addr & `FSPC_PAGE_ADDR_MASK; // RULE11
		end
	endfunction

	// oscillator is foreign: two flops, then edge detect on the second and third
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			osc_sync_reg <= 3'h0;
		end else if (clk_en) begin
			osc_sync_reg <= {osc_sync_reg[1:0], fast_rc_osc};
		end
	end
	assign osc_tick = osc_sync_reg[1] & ~osc_sync_reg[2]; // RULE2

	assign wr_ctrl = reg_wr && reg_addr == `FSPC_ADDR_CONTROL;
	assign wr_key = reg_wr && reg_addr == `FSPC_ADDR_KEY;
	assign start_req = wr_ctrl && reg_wdata[`FSPC_BIT_START] && !ctrl_reg[`FSPC_BIT_START];
	assign sel_op = decode_op(reg_wdata[`FSPC_BIT_ERASE], reg_wdata[3:0]);

	// key sequencer and control register next state
	always_comb begin
		ctrl_next = ctrl_reg;
		key_next = key_reg;
		cmd_next = cmd_reg;
		load = 1'b0;
		launch = 1'b0;
		load_cycles = 16'h0000;
		if (reg_wr) begin
			key_next = FSPC_LOCKED; // RULE21
			if (wr_key && reg_wdata[7:0] == `FSPC_KEY_FIRST) begin
				key_next = FSPC_HALF; // RULE5
			end else if (wr_key && key_reg == FSPC_HALF && reg_wdata[7:0] == `FSPC_KEY_SECOND) begin
				key_next = FSPC_ARMED; // RULE21
			end
		end
		if (wr_ctrl && !ctrl_reg[`FSPC_BIT_START]) begin
			// start stays untouched here: software can never clear it
			ctrl_next = (ctrl_reg & ~`FSPC_CONTROL_WMASK) | (reg_wdata & `FSPC_CONTROL_WMASK); // RULE6
		end
		if (start_req) begin
			if (key_reg == FSPC_ARMED && reg_wdata[`FSPC_BIT_OP_WRITE_ENABLE] && sel_op != FSPC_NONE) begin
				ctrl_next[`FSPC_BIT_START] = 1'b1; // RULE3
				ctrl_next[`FSPC_BIT_SEQERR] = 1'b0;
				cmd_next.start = 1'b1;
				cmd_next.erase = reg_wdata[`FSPC_BIT_ERASE];
				cmd_next.op = sel_op;
				cmd_next.addr = align_addr(sel_op, {table_page_reg, table_ea}); // RULE20
				launch = 1'b1;
				load = 1'b1;
				load_cycles = op_cycles(sel_op);
			end else if (reg_wdata[`FSPC_BIT_OP_WRITE_ENABLE] && sel_op == FSPC_NONE) begin
				ctrl_next[`FSPC_BIT_SEQERR] = ctrl_reg[`FSPC_BIT_SEQERR]; // no-op codes do nothing
			end else begin
				ctrl_next[`FSPC_BIT_SEQERR] = 1'b1; // RULE8
			end
		end
		if (ctrl_reg[`FSPC_BIT_START] && (done || abort)) begin
			ctrl_next[`FSPC_BIT_START] = 1'b0; // RULE3
			ctrl_next[`FSPC_BIT_SEQERR] = abort; // RULE8
			cmd_next.start = 1'b0;
			// a cut operation must not leave the timer running behind a released core
			load = abort; // RULE1
		end
		if (ctrl_reg[`FSPC_BIT_START]) begin
			key_next = FSPC_LOCKED;
		end
	end

	// control bits clear on power-on only; warm reset merely drops the key state
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= `FSPC_CONTROL_RESET; // RULE22
			key_reg <= FSPC_LOCKED;
			cmd_reg <= '0;
		end else if (clk_en) begin
			ctrl_reg <= ctrl_next;
			key_reg <= warm_rst ? FSPC_LOCKED : key_next;
			cmd_reg <= cmd_next;
		end
	end

	fspc_timer u_timer (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.load(load),
		.cycles(load_cycles),
		.osc_tick(osc_tick & ~abort),
		.busy(busy),
		.done(done)
	);

	// key register is write-only and reads zero
	assign reg_rdata = (reg_addr == `FSPC_ADDR_CONTROL) ? ctrl_reg : 16'h0000; // RULE5
	assign cpu_stall = ctrl_reg[`FSPC_BIT_START]; // RULE1
	assign flash_cmd = cmd_reg;

	// stall must cover the whole timed run
	property p_stall_while_busy;
		@(posedge ref_clk) disable iff (!arst_n) busy |-> cpu_stall;
	endproperty
	a_stall_while_busy: assert property (p_stall_while_busy) // RULE1
		else $error("stall dropped while operation runs");

	// start falls only through completion or abort
	property p_done_clears_start;
		@(posedge ref_clk) disable iff (!arst_n)
		(done && clk_en && ctrl_reg[`FSPC_BIT_START]) |=> !ctrl_reg[`FSPC_BIT_START];
	endproperty
	a_done_clears_start: assert property (p_done_clears_start) // RULE3
		else $error("start bit not cleared on completion");
	property p_no_sw_clear;
		@(posedge ref_clk) disable iff (!arst_n)
		(ctrl_reg[`FSPC_BIT_START] && !done && !abort) |=> ctrl_reg[`FSPC_BIT_START];
	endproperty
	a_no_sw_clear: assert property (p_no_sw_clear) // RULE6
		else $error("start bit cleared without completion");

	// error flag: set on cut run or on refused start other than a write-enabled no-op code, clear after a clean one
	property p_locked_start_err;
		@(posedge ref_clk) disable iff (!arst_n)
		(clk_en && start_req && key_reg != FSPC_ARMED) |=> ctrl_reg[`FSPC_BIT_SEQERR] && !cpu_stall;
	endproperty
	a_locked_start_err: assert property (p_locked_start_err) // RULE8
		else $error("unarmed start not flagged");
	property p_clean_done;
		@(posedge ref_clk) disable iff (!arst_n)
		(clk_en && done && !abort && ctrl_reg[`FSPC_BIT_START]) |=> !ctrl_reg[`FSPC_BIT_SEQERR];
	endproperty
	a_clean_done: assert property (p_clean_done) // RULE8
		else $error("error flag set after normal completion");
	property p_abort_stops;
		@(posedge ref_clk) disable iff (!arst_n)
		(clk_en && ctrl_reg[`FSPC_BIT_START] && abort) |=> !busy && !cpu_stall && ctrl_reg[`FSPC_BIT_SEQERR];
	endproperty
	a_abort_stops: assert property (p_abort_stops) // RULE8
		else $error("cut operation left running or unflagged");

	// key register is write-only
	property p_key_reads_zero;
		@(posedge ref_clk) disable iff (!arst_n) reg_addr == `FSPC_ADDR_KEY |-> reg_rdata == 16'h0000;
	endproperty
	a_key_reads_zero: assert property (p_key_reads_zero) // RULE5
		else $error("key register readable");

	// refused starts never stall the core
	property p_no_op_write_enable_no_run;
		@(posedge ref_clk) disable iff (!arst_n)
		(clk_en && start_req && !reg_wdata[`FSPC_BIT_OP_WRITE_ENABLE] && !cpu_stall) |=> !cpu_stall;
	endproperty
	a_no_op_write_enable_no_run: assert property (p_no_op_write_enable_no_run) // RULE7
		else $error("operation started without write enable");
	property p_intervening_write;
		@(posedge ref_clk) disable iff (!arst_n)
		(clk_en && key_reg == FSPC_HALF && reg_wr && !wr_key) |=> key_reg == FSPC_LOCKED;
	endproperty
	a_intervening_write: assert property (p_intervening_write) // RULE21
		else $error("unlock survived intervening write");
	property p_nop_code;
		@(posedge ref_clk) disable iff (!arst_n)
		(clk_en && start_req && sel_op == FSPC_NONE && !cpu_stall) |=> !cpu_stall;
	endproperty
	a_nop_code: assert property (p_nop_code) // RULE9
		else $error("no-operation code started");

	// timing and target address of an accepted start
	property p_row_duration;
		@(posedge ref_clk) disable iff (!arst_n) (clk_en && launch) |=> busy [*8];
	endproperty
	a_row_duration: assert property (p_row_duration) // RULE2
		else $error("operation ended too early");
	property p_addr_capture;
		@(posedge ref_clk) disable iff (!arst_n)
		(clk_en && launch) |=> flash_cmd.addr[23:10] == {$past(table_page_reg), $past(table_ea[15:10])};
	endproperty
	a_addr_capture: assert property (p_addr_capture) // RULE20
		else $error("target address mis-formed");
	property p_row_aligned;
		@(posedge ref_clk) disable iff (!arst_n)
		(flash_cmd.start && flash_cmd.op == FSPC_ROW) |-> flash_cmd.addr[6:0] == 7'h00;
	endproperty
	a_row_aligned: assert property (p_row_aligned) // RULE19
		else $error("row target off its boundary");

	c_page_erase: cover property (@(posedge ref_clk) launch && sel_op == FSPC_PAGE);
	c_row_prog: cover property (@(posedge ref_clk) launch && sel_op == FSPC_ROW);
	c_seq_err: cover property (@(posedge ref_clk) $rose(ctrl_reg[`FSPC_BIT_SEQERR]));
	c_complete: cover property (@(posedge ref_clk) $fell(cpu_stall) && !ctrl_reg[`FSPC_BIT_SEQERR]);
endmodule

// ==== logic/fspc_regs.svh ====
// offsets, field positions, reset values and timing counts of the flash self-programming controller
// assumes a 16-bit special-function register port with word addresses decoded by the core
`ifndef FSPC_REGS_SVH
`define FSPC_REGS_SVH
`define FSPC_ADDR_CONTROL 4'h0
`define FSPC_ADDR_KEY 4'h1
`define FSPC_BIT_START 15
`define FSPC_BIT_OP_WRITE_ENABLE 14
`define FSPC_BIT_SEQERR 13
`define FSPC_BIT_ERASE 6
`define FSPC_CONTROL_RESET 16'h0000
`define FSPC_CONTROL_WMASK 16'h404f
`define FSPC_KEY_FIRST 8'h55
`define FSPC_KEY_SECOND 8'haa
`define FSPC_OP_BULK 4'hf
`define FSPC_OP_SEGMENT 4'hd
`define FSPC_OP_PAGE 4'h2
`define FSPC_OP_CFG 4'h0
`define FSPC_OP_ROW 4'h1
`define FSPC_OP_WORD 4'h3
`define FSPC_ROW_OSC_CYCLES 11064
`define FSPC_OSC_KHZ 7370
`define FSPC_ROWS_PER_PAGE 8
`define FSPC_WORDS_PER_ROW 64
`define FSPC_SHORT_OSC_CYCLES 256
`define FSPC_ADDR_PER_WORD 2
`define FSPC_ROW_ADDR_MASK 24'hffff80
`define FSPC_PAGE_ADDR_MASK 24'hfffc00
`endif

// ==== logic/fspc_pkg.sv ====
// types of the flash self-programming controller
// no constants here; numeric values live in fspc_regs.svh
package fspc_pkg;
	typedef enum logic [2:0] {FSPC_NONE, FSPC_BULK, FSPC_SEGMENT, FSPC_PAGE, FSPC_CFG_ERASE,
		FSPC_ROW, FSPC_WORD, FSPC_CFG_PROG} fspc_op_e;
	typedef enum logic [1:0] {FSPC_LOCKED, FSPC_HALF, FSPC_ARMED} fspc_key_e;
	typedef struct packed {
		logic start;
		logic erase;
		fspc_op_e op;
		logic [23:0] addr;
	} fspc_cmd_s;
endpackage

// ==== logic/fspc_timer.sv ====
// self-timer that counts fast RC oscillator edges for one flash operation
// assumes osc_tick is a single-cycle pulse already synchronised to ref_clk
`timescale 1ns/1ps
module fspc_timer
	import fspc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic load,
	input wire logic [15:0] cycles,
	input wire logic osc_tick,
	output logic busy,
	output logic done
);
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic done_reg;
	logic done_next;

	// count down on oscillator ticks only, so duration tracks oscillator tuning
	always_comb begin
		cnt_next = cnt_reg;
		done_next = 1'b0;
		if (load) begin
			cnt_next = cycles;
		end else if (cnt_reg != 16'h0000 && osc_tick) begin
			cnt_next = cnt_reg - 16'h0001;
			done_next = (cnt_reg == 16'h0001);
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 16'h0000;
			done_reg <= 1'b0;
		end else if (clk_en) begin
			cnt_reg <= cnt_next;
			done_reg <= done_next;
		end
	end

	assign busy = (cnt_reg != 16'h0000);
	assign done = done_reg;
endmodule

// ==== tb/fspc_core_model.sv ====
// core model: issues control and key writes the way self-programming software does
// assumes the controller takes one-cycle write strobes on rising ref_clk, reads combinational
`timescale 1ns/1ps
`include "fspc_regs.svh"
module fspc_core_model (
	input wire logic ref_clk,
	input wire logic [15:0] reg_rdata,
	output logic reg_wr,
	output logic [3:0] reg_addr,
	output logic [15:0] reg_wdata
);
	// idle bus at time zero
	initial begin
		reg_wr = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
	end
	// holding buffers live on the core side; the controller never sees the latches
	logic [15:0] hold_low [`FSPC_WORDS_PER_ROW];
	logic [7:0] hold_high [`FSPC_WORDS_PER_ROW];
	int hold_count;
	// one full row of buffer loads, low word then high byte, then advance
	task automatic load_row(input logic [15:0] seed);
		hold_count = 0;
		for (int w = 0; w < `FSPC_WORDS_PER_ROW; w++) begin
			hold_low[w] = seed + 16'(w);
			hold_high[w] = 8'(w);
			hold_count++;
		end
	endtask
	// strobe held across exactly one sampling edge
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge ref_clk);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~d; // stale data must not look valid
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		reg_addr = a;
		#1;
		d = reg_rdata;
	endtask
	// configure, two keys with nothing between, then start; idle after start
	task automatic launch(input logic [15:0] ctrl);
		wr(`FSPC_ADDR_CONTROL, ctrl & 16'h7fff);
		wr(`FSPC_ADDR_KEY, {8'h00, `FSPC_KEY_FIRST});
		wr(`FSPC_ADDR_KEY, {8'h00, `FSPC_KEY_SECOND});
		wr(`FSPC_ADDR_CONTROL, ctrl | 16'h8000);
	endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the flash self-programming controller
// assumes a free-running oscillator near 7.37 MHz; clk_en tied high
`timescale 1ns/1ps
`include "fspc_regs.svh"
module testbench;
	import fspc_pkg::*;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic warm_rst = 1'b0;
	logic fast_rc_osc = 1'b0;
	logic abort = 1'b0;
	logic [7:0] tpage = 8'h00;
	logic [15:0] tea = 16'h0000;
	logic reg_wr;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic [15:0] r;
	logic [23:0] ea;
	logic cpu_stall;
	fspc_cmd_s flash_cmd;
	logic [15:0] lfsr = 16'h001b;
	int num_errors = 0;
	int samples_checked = 0;
	int n;
	logic [15:0] op_ctrl[7] = '{16'h4042, 16'h404f, 16'h404d, 16'h4001, 16'h4003, 16'h4000, 16'h4040};
	fspc_op_e op_exp[7] = '{FSPC_PAGE, FSPC_BULK, FSPC_SEGMENT, FSPC_ROW, FSPC_WORD, FSPC_CFG_PROG, FSPC_CFG_ERASE};
	int op_ticks[7] = '{0, 0, 0, `FSPC_ROW_OSC_CYCLES, `FSPC_SHORT_OSC_CYCLES, `FSPC_SHORT_OSC_CYCLES,
		`FSPC_SHORT_OSC_CYCLES};
	logic [15:0] noop_ctrl[5] = '{16'h4043, 16'h4041, 16'h400f, 16'h400d, 16'h4002};
	// 25 MHz system clock and unrelated oscillator
	always #20 ref_clk = ~ref_clk;
	always #67.84 fast_rc_osc = ~fast_rc_osc;
	fspc_core_model fspc_core_model_inst (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));
	fspc_ctrl fspc_ctrl_inst (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(1'b1), .warm_rst(warm_rst),
		.fast_rc_osc(fast_rc_osc), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.table_page_reg(tpage), .table_ea(tea), .abort(abort),
		.reg_rdata(reg_rdata), .cpu_stall(cpu_stall), .flash_cmd(flash_cmd));
	function automatic logic [15:0] rand16();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction
	// osc period over clock period, plus sync and register latency
	function automatic int exp_cycles(input int ticks);
		return int'(ticks * 3.392) + 3;
	endfunction
	// rows span twice their word count in program addresses, pages eight rows
	function automatic logic [23:0] exp_addr(input fspc_op_e op, input logic [23:0] a);
		int span;
		span = 1;
		if (op == FSPC_ROW) begin
			span = `FSPC_ADDR_PER_WORD * `FSPC_WORDS_PER_ROW;
		end
		if (op == FSPC_PAGE) begin
			span = `FSPC_ADDR_PER_WORD * `FSPC_WORDS_PER_ROW * `FSPC_ROWS_PER_PAGE;
		end
		return a - 24'(a % span);
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// start bit, error flag, stall
	task automatic chk_status(input logic [2:0] exp);
		fspc_core_model_inst.rd(`FSPC_ADDR_CONTROL, r);
		chk({13'h0000, r[15], r[13], cpu_stall}, {13'h0000, exp});
	endtask
	task automatic pulse(ref logic s);
		@(posedge ref_clk);
		#1 s = 1'b1;
		@(posedge ref_clk);
		#1 s = 1'b0;
	endtask
	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// one operation; table-driven code, random target address
	task automatic run_op(input int i);
		tpage = 8'(rand16());
		tea = rand16();
		if (op_exp[i] == FSPC_ROW) begin
			fspc_core_model_inst.load_row(rand16());
		end
		fspc_core_model_inst.launch(op_ctrl[i]);
		ea = exp_addr(op_exp[i], {tpage, tea});
		fspc_core_model_inst.rd(`FSPC_ADDR_CONTROL, r);
		chk(r, op_ctrl[i] | 16'h8000);
		chk({15'h0000, cpu_stall}, 16'h0001);
		chk({13'h0000, flash_cmd.op}, {13'h0000, op_exp[i]});
		chk(flash_cmd.addr[15:0], ea[15:0]);
		chk({8'h00, flash_cmd.addr[23:16]}, {8'h00, ea[23:16]});
		chk({14'h0000, flash_cmd.start, flash_cmd.erase}, {14'h0000, 1'b1, op_ctrl[i][`FSPC_BIT_ERASE]});
		fspc_core_model_inst.wr(`FSPC_ADDR_CONTROL, 16'h0000);
		chk_status(3'b101);
		if (op_ticks[i] == 0) begin
			pulse(abort);
			chk_status(3'b010);
		end else begin
			n = 2;
			while (cpu_stall === 1'b1 && n < 40000) begin
				@(posedge ref_clk);
				#1 n++;
			end
			chk({15'h0000, n > exp_cycles(op_ticks[i]) - 6 && n < exp_cycles(op_ticks[i]) + 6}, 16'h0001);
			chk_status(3'b000);
		end
		chk({15'h0000, flash_cmd.start}, 16'h0000);
	endtask
	// watchdog sized well above the one long row write
	initial begin
		#3000000;
		num_errors++;
		$display("BAD %0t timeout", $time);
		stop_test();
	end
	// main sequence
	initial begin
		repeat (20) @(posedge ref_clk);
		#1 arst_n = 1'b1;
		chk_status(3'b000);
		chk(r, `FSPC_CONTROL_RESET);
		fspc_core_model_inst.wr(`FSPC_ADDR_KEY, rand16() | 16'hff00);
		fspc_core_model_inst.rd(`FSPC_ADDR_KEY, r);
		chk(r, 16'h0000);
		foreach (noop_ctrl[i]) begin
			fspc_core_model_inst.launch(noop_ctrl[i]);
			chk_status(3'b000);
		end
		fspc_core_model_inst.wr(`FSPC_ADDR_CONTROL, 16'hc001);
		chk_status(3'b010);
		fspc_core_model_inst.wr(`FSPC_ADDR_KEY, 16'h0055);
		fspc_core_model_inst.wr(`FSPC_ADDR_KEY, 16'h0056);
		fspc_core_model_inst.wr(`FSPC_ADDR_CONTROL, 16'hc001);
		chk_status(3'b010);
		fspc_core_model_inst.wr(`FSPC_ADDR_KEY, 16'h0055);
		fspc_core_model_inst.wr(`FSPC_ADDR_CONTROL, 16'h4001);
		fspc_core_model_inst.wr(`FSPC_ADDR_KEY, 16'h00aa);
		fspc_core_model_inst.wr(`FSPC_ADDR_CONTROL, 16'hc001);
		chk_status(3'b010);
		fspc_core_model_inst.launch(16'h8001);
		chk_status(3'b010);
		// page rewrite row by row; each row is cut short to keep the run brief
		for (int k = 0; k < `FSPC_ROWS_PER_PAGE; k++) begin
			fspc_core_model_inst.load_row(rand16());
			tea = 16'(k * `FSPC_ADDR_PER_WORD * `FSPC_WORDS_PER_ROW);
			fspc_core_model_inst.launch(16'h4001);
			chk({15'h0000, cpu_stall}, 16'h0001);
			chk(flash_cmd.addr[15:0], tea);
			pulse(abort);
		end
		foreach (op_ctrl[i]) run_op(i);
		fspc_core_model_inst.wr(`FSPC_ADDR_CONTROL, 16'h4042);
		pulse(warm_rst);
		fspc_core_model_inst.rd(`FSPC_ADDR_CONTROL, r);
		chk(r, 16'h4042);
		fspc_core_model_inst.wr(`FSPC_ADDR_KEY, 16'h0055);
		fspc_core_model_inst.wr(`FSPC_ADDR_KEY, 16'h00aa);
		pulse(warm_rst);
		fspc_core_model_inst.wr(`FSPC_ADDR_CONTROL, 16'hc042);
		chk_status(3'b010);
		stop_test();
	end
endmodule
